// ### rtl/tmcu_defines.vh
// Purpose: Offsets, field positions, reset values, mode and response codes and prescaler width of the timer control unit.
// Assumes: Included by bare name from the design files.
// Notes: Byte addresses are four times the register index.
`ifndef TMCU_DEFINES_VH
`define TMCU_DEFINES_VH
`define TMCU_IDX_CLK_FLAG      8'hba
`define TMCU_IDX_EN_MODE       8'hbb
`define TMCU_IDX_PERIOD_LO     8'hbc
`define TMCU_IDX_PERIOD_HI     8'hbd
`define TMCU_IDX_DUTY_LO       8'hbe
`define TMCU_IDX_DUTY_HI       8'hbf
`define TMCU_IDX_IRQ_STATUS    8'hc0
`define TMCU_IDX_IRQ_MASK      8'hc1
`define TMCU_IDX_COUNT_LO      8'hc2
`define TMCU_IDX_COUNT_HI      8'hc3
`define TMCU_BIT_RUN_EN        7
`define TMCU_BIT_MODE_HI       5
`define TMCU_BIT_MODE_LO       4
`define TMCU_BIT_CLR           0
`define TMCU_BIT_CSEL_HI       7
`define TMCU_BIT_CSEL_LO       5
`define TMCU_BIT_IRQ_FLAG      4
`define TMCU_BIT_POL           2
`define TMCU_BIT_EDGE          1
`define TMCU_BIT_SNAP          0
`define TMCU_RST_CTRL          8'h00
`define TMCU_RST_DATA          16'hffff
`define TMCU_MODE_TIMER        2'h0
`define TMCU_MODE_CAPTURE      2'h1
`define TMCU_MODE_ONESHOT      2'h2
`define TMCU_MODE_REPEAT       2'h3
`define TMCU_CSEL_EXT          3'h7
`define TMCU_PRESCALE_W        11
`define TMCU_AXI_OKAY          2'h0
`define TMCU_AXI_DECERR        2'h3
`endif

// ### rtl/tmcu_prescaler.v
// Purpose: Free running prescaler giving one-cycle enable taps of the system clock.
// Assumes: Single clock domain, synchronous active high reset.
// Notes: Tap order follows the clock-select codes 0 to 6.
`include "tmcu_defines.vh"
`default_nettype none
module tmcu_prescaler #(
	parameter W = `TMCU_PRESCALE_W
) (
	input  wire       i_sys_clk,  // System clock.
	input  wire       i_sys_rst,  // Synchronous reset, active high.
	input  wire [2:0] i_sel,      // Clock-select code.
	output reg        o_tick_ff   // One-cycle count enable.
);
	reg  [W-1:0] div_ff;          // Prescaler count.
	reg  [W-1:0] nxt_all;         // Next count.
	reg          tap;             // Selected tap wrap.

	// Select the wrap of the chosen division; divide by one fires every cycle.
	always @* begin
		nxt_all = div_ff + {{(W-1){1'b0}}, 1'b1};
		case (i_sel)
			3'h0: tap = (div_ff[10:0] == 11'h7ff);
			3'h1: tap = (div_ff[8:0] == 9'h1ff);
			3'h2: tap = (div_ff[5:0] == 6'h3f);
			3'h3: tap = (div_ff[2:0] == 3'h7);
			3'h4: tap = (div_ff[1:0] == 2'h3);
			3'h5: tap = div_ff[0];
			3'h6: tap = 1'b1;
			default: tap = 1'b0;
		endcase
	end

	// Count continuously and register the enable.
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			div_ff    <= {W{1'b0}};
			o_tick_ff <= 1'b0;
		end else begin
			div_ff    <= nxt_all;
			o_tick_ff <= tap;
		end
	end
endmodule // tmcu_prescaler
`default_nettype wire

// ### rtl/tmcu_timer.v
// Purpose: 16-bit timer control unit with clock select, modes, capture and pulse output.
// Assumes: AXI4-Lite slave, 32-bit data, one write and one read at a time.
// Notes: The A-match pulse is exported as a count source for the second timer.
//
// Our own choice: the AXI4-Lite slave port.
`include "tmcu_defines.vh"
`default_nettype none
// How it works
// - Enable set clears counter and starts counting.
// - Mode field picks timer, capture, one-shot, repeat.
// - Capture mode still raises A-match interrupt.
// - Counter clear bit clears counter, self-clears.
// - Clock select picks prescaled tap or pin.
// - Interrupt flag sets on timer interrupt.
// - Flag cleared by zero write or acknowledge.
// - Polarity sets start level and idle level.
// - Edge bit picks falling or rising pin edge.
// - Snapshot bit copies counter into B register.
// - A-match pulse exported to second timer.
// - Counter equals A: match, interrupt, clear.
// - Capture edge loads counter into B register.
// - A sets period, B sets duty.
module tmcu_timer (
	input  wire        i_sys_clk,     // System clock, 100 MHz.
	input  wire        i_sys_rst,     // Synchronous reset, active high.
	input  wire [31:0] s_axi_awaddr,  // Write address.
	input  wire        s_axi_awvalid, // Write address valid.
	output reg         s_axi_awready, // Write address ready.
	input  wire [31:0] s_axi_wdata,   // Write data.
	input  wire [3:0]  s_axi_wstrb,   // Write byte strobes.
	input  wire        s_axi_wvalid,  // Write data valid.
	output reg         s_axi_wready,  // Write data ready.
	output reg  [1:0]  s_axi_bresp,   // Write response.
	output reg         s_axi_bvalid,  // Write response valid.
	input  wire        s_axi_bready,  // Write response ready.
	input  wire [31:0] s_axi_araddr,  // Read address.
	input  wire        s_axi_arvalid, // Read address valid.
	output reg         s_axi_arready, // Read address ready.
	output reg  [31:0] s_axi_rdata,   // Read data.
	output reg  [1:0]  s_axi_rresp,   // Read response.
	output reg         s_axi_rvalid,  // Read data valid.
	input  wire        s_axi_rready,  // Read data ready.
	input  wire        i_ext_count_clock,     // External count clock pin.
	input  wire        i_capture_trigger_input, // Capture trigger pin.
	input  wire        i_capture_rising,      // Capture edge polarity, 1 rising.
	input  wire        i_int_ack,             // Interrupt acknowledge pulse.
	output reg         o_match_toggle_out_ff, // Toggle output in timer mode.
	output reg         o_pulse_out_ff,        // Pulse output in pulse modes.
	output reg         o_a_match_ff,          // A-match pulse for second timer.
	output reg         o_irq_ff               // Level interrupt.
);
	reg        run_enable_ff;         // Timer running.
	reg  [1:0] operating_mode_sel_ff; // Operating mode.
	reg  [2:0] count_clock_sel_ff;    // Clock select.
	reg        irq_flag_ff;           // Timer interrupt flag.
	reg        output_polarity_ff;    // Output polarity.
	reg        ext_edge_sel_ff;       // External edge select.
	reg  [15:0] period_compare_value_ff; // A data value.
	reg  [15:0] duty_capture_value_ff;   // B data value.
	reg  [15:0] up_counter_ff;        // Counter.
	reg  [1:0] sts_ff;                // Sticky status: 0 match, 1 capture.
	reg  [1:0] msk_ff;                // Interrupt mask.
	reg        done_ff;               // One-shot finished.
	reg  [2:0] ext_sync_ff;           // Pin sync stages and edge history.
	reg  [2:0] cap_sync_ff;           // Capture sync stages and history.
	reg  [31:0] aw_ff;                // Latched write address.
	reg  [31:0] wd_ff;                // Latched write data.
	reg  [3:0] ws_ff;                 // Latched strobes.
	reg        aw_ok_ff;              // Address held.
	reg        w_ok_ff;               // Data held.
	wire       pre_tick;              // Prescaler enable.
	wire       ext_rise;              // Pin rising edge.
	wire       ext_fall;              // Pin falling edge.
	wire       cap_edge;              // Capture edge.
	wire       tick;                  // Count enable.
	wire       match;                 // Counter equals A.
	wire       do_wr;                 // Write performed.
	wire [7:0] widx;                  // Write register index.
	wire [7:0] wbyte;                 // Written byte.
	wire       pulse_mode;            // One-shot or repeat.
	reg  [7:0] rbyte;                 // Read mux.
	reg        rhit;                  // Read address mapped.
	reg        whit;                  // Write address mapped.

	tmcu_prescaler #(.W(`TMCU_PRESCALE_W)) u_pre (
		.i_sys_clk (i_sys_clk),
		.i_sys_rst (i_sys_rst),
		.i_sel     (count_clock_sel_ff),
		.o_tick_ff (pre_tick)
	);

	// Edges look only at the second and third stages of each synchroniser.
	assign ext_rise = ext_sync_ff[1] & ~ext_sync_ff[2];
	assign ext_fall = ~ext_sync_ff[1] & ext_sync_ff[2];
	assign cap_edge = i_capture_rising ? (cap_sync_ff[1] & ~cap_sync_ff[2])
	                                   : (~cap_sync_ff[1] & cap_sync_ff[2]);
	assign tick = (count_clock_sel_ff == `TMCU_CSEL_EXT) ?
	              (ext_edge_sel_ff ? ext_rise : ext_fall) : pre_tick;
	assign pulse_mode = operating_mode_sel_ff[1];
	assign match = run_enable_ff & ~done_ff & tick &
	               (up_counter_ff == period_compare_value_ff);
	assign do_wr = aw_ok_ff & w_ok_ff & ~s_axi_bvalid;
	assign widx  = aw_ff[9:2];
	assign wbyte = wd_ff[7:0];

	// Address decode for reads and writes, unused bits read zero.
	always @* begin
		rbyte = 8'h00;
		rhit  = 1'b1;
		case (s_axi_araddr[9:2])
			`TMCU_IDX_CLK_FLAG: rbyte = {count_clock_sel_ff, irq_flag_ff, 1'b0,
			                             output_polarity_ff, ext_edge_sel_ff, 1'b0};
			`TMCU_IDX_EN_MODE: rbyte = {run_enable_ff, 1'b0, operating_mode_sel_ff, 4'h0};
			`TMCU_IDX_PERIOD_LO: rbyte = period_compare_value_ff[7:0];
			`TMCU_IDX_PERIOD_HI: rbyte = period_compare_value_ff[15:8];
			`TMCU_IDX_DUTY_LO: rbyte = duty_capture_value_ff[7:0];
			`TMCU_IDX_DUTY_HI: rbyte = duty_capture_value_ff[15:8];
			`TMCU_IDX_IRQ_STATUS: rbyte = {6'h00, sts_ff};
			`TMCU_IDX_IRQ_MASK: rbyte = {6'h00, msk_ff};
			`TMCU_IDX_COUNT_LO: rbyte = up_counter_ff[7:0];
			`TMCU_IDX_COUNT_HI: rbyte = up_counter_ff[15:8];
			default: rhit = 1'b0;
		endcase
		case (widx)
			`TMCU_IDX_CLK_FLAG, `TMCU_IDX_EN_MODE, `TMCU_IDX_PERIOD_LO,
			`TMCU_IDX_PERIOD_HI, `TMCU_IDX_DUTY_LO, `TMCU_IDX_DUTY_HI,
			`TMCU_IDX_IRQ_STATUS, `TMCU_IDX_IRQ_MASK,
			`TMCU_IDX_COUNT_LO, `TMCU_IDX_COUNT_HI: whit = 1'b1;
			default: whit = 1'b0;
		endcase
	end

	// AXI4-Lite write channel: take address and data in any order, answer once both held.
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `TMCU_AXI_OKAY;
			aw_ok_ff      <= 1'b0;
			w_ok_ff       <= 1'b0;
			aw_ff         <= 32'h0;
			wd_ff         <= 32'h0;
			ws_ff         <= 4'h0;
		end else begin
			s_axi_awready <= ~aw_ok_ff & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_ok_ff & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_ff    <= s_axi_awaddr;
				aw_ok_ff <= 1'b1;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wd_ff   <= s_axi_wdata;
				ws_ff   <= s_axi_wstrb;
				w_ok_ff <= 1'b1;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= whit ? `TMCU_AXI_OKAY : `TMCU_AXI_DECERR;
				aw_ok_ff     <= 1'b0;
				w_ok_ff      <= 1'b0;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel: one cycle accept, data registered the next.
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `TMCU_AXI_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h0, rbyte};
				s_axi_rresp  <= rhit ? `TMCU_AXI_OKAY : `TMCU_AXI_DECERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Control registers, counter, capture and flags.
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			run_enable_ff           <= 1'b0;
			operating_mode_sel_ff   <= `TMCU_MODE_TIMER;
			count_clock_sel_ff      <= 3'h0;
			irq_flag_ff             <= 1'b0;
			output_polarity_ff      <= 1'b0;
			ext_edge_sel_ff         <= 1'b0;
			period_compare_value_ff <= `TMCU_RST_DATA;
			duty_capture_value_ff   <= `TMCU_RST_DATA;
			up_counter_ff           <= 16'h0;
			sts_ff                  <= 2'h0;
			msk_ff                  <= 2'h0;
			done_ff                 <= 1'b0;
			ext_sync_ff             <= 3'h0;
			cap_sync_ff             <= 3'h0;
			o_a_match_ff            <= 1'b0;
			o_irq_ff                <= 1'b0;
		end else begin
			ext_sync_ff  <= {ext_sync_ff[1:0], i_ext_count_clock};
			cap_sync_ff  <= {cap_sync_ff[1:0], i_capture_trigger_input};
			o_a_match_ff <= match;
			o_irq_ff     <= |(sts_ff & msk_ff);
			// Counting: a match clears the counter, otherwise advance on each enable.
			if (run_enable_ff & ~done_ff & tick)
				up_counter_ff <= match ? 16'h0 : up_counter_ff + 16'h1;
			if (match & (operating_mode_sel_ff == `TMCU_MODE_ONESHOT))
				done_ff <= 1'b1;
			if ((operating_mode_sel_ff == `TMCU_MODE_CAPTURE) & run_enable_ff & cap_edge)
				duty_capture_value_ff <= up_counter_ff;
			if (do_wr & ws_ff[0]) begin
				case (widx)
					`TMCU_IDX_CLK_FLAG: begin
						count_clock_sel_ff <= wbyte[`TMCU_BIT_CSEL_HI:`TMCU_BIT_CSEL_LO];
						output_polarity_ff <= wbyte[`TMCU_BIT_POL];
						ext_edge_sel_ff    <= wbyte[`TMCU_BIT_EDGE];
						if (wbyte[`TMCU_BIT_SNAP])
							duty_capture_value_ff <= up_counter_ff;
					end
					`TMCU_IDX_EN_MODE: begin
						run_enable_ff         <= wbyte[`TMCU_BIT_RUN_EN];
						operating_mode_sel_ff <= wbyte[`TMCU_BIT_MODE_HI:`TMCU_BIT_MODE_LO];
						if ((wbyte[`TMCU_BIT_RUN_EN] & ~run_enable_ff) | wbyte[`TMCU_BIT_CLR]) begin
							up_counter_ff <= 16'h0;
							done_ff       <= 1'b0;
						end
					end
					`TMCU_IDX_PERIOD_LO: period_compare_value_ff[7:0] <= wbyte;
					`TMCU_IDX_PERIOD_HI: period_compare_value_ff[15:8] <= wbyte;
					`TMCU_IDX_DUTY_LO: duty_capture_value_ff[7:0] <= wbyte;
					`TMCU_IDX_DUTY_HI: duty_capture_value_ff[15:8] <= wbyte;
					`TMCU_IDX_IRQ_MASK: msk_ff <= wbyte[1:0];
					default: ;
				endcase
			end
			// Flag: zero write or acknowledge clears, a match in the same cycle wins.
			if (match)
				irq_flag_ff <= 1'b1;
			else if (i_int_ack | (do_wr & ws_ff[0] & (widx == `TMCU_IDX_CLK_FLAG) &
			         ~wbyte[`TMCU_BIT_IRQ_FLAG]))
				irq_flag_ff <= 1'b0;
			// Sticky status, write one to clear, set wins.
			sts_ff <= (sts_ff & ~((do_wr & ws_ff[0] & (widx == `TMCU_IDX_IRQ_STATUS)) ?
			          wbyte[1:0] : 2'h0)) |
			          {(operating_mode_sel_ff == `TMCU_MODE_CAPTURE) & run_enable_ff & cap_edge,
			           match};
		end
	end

	// Outputs: toggle on match in timer mode, pulse high until B then low in pulse modes.
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_match_toggle_out_ff <= 1'b0;
			o_pulse_out_ff        <= 1'b0;
		end else if (~run_enable_ff | done_ff) begin
			o_match_toggle_out_ff <= output_polarity_ff;
			o_pulse_out_ff        <= output_polarity_ff;
		end else begin
			if (match & (operating_mode_sel_ff == `TMCU_MODE_TIMER))
				o_match_toggle_out_ff <= ~o_match_toggle_out_ff;
			if (pulse_mode)
				o_pulse_out_ff <= output_polarity_ff ^
				                  (up_counter_ff < duty_capture_value_ff);
		end
	end
endmodule // tmcu_timer
`default_nettype wire

// ### verification/tmcu_timer_props.sv
// Purpose: Port-level checks of the timer control unit.
// Assumes: One clock domain, synchronous active high reset.
// Notes: Bound to every instance of the timer module.
`include "tmcu_defines.vh"
`default_nettype none
module tmcu_props (
	input wire logic       i_sys_clk,     // System clock.
	input wire logic       i_sys_rst,     // Synchronous reset.
	input wire logic       s_axi_awready, // Write address ready.
	input wire logic       s_axi_wready,  // Write data ready.
	input wire logic       s_axi_bvalid,  // Write response valid.
	input wire logic       s_axi_bready,  // Write response ready.
	input wire logic       s_axi_arvalid, // Read address valid.
	input wire logic       s_axi_arready, // Read address ready.
	input wire logic       s_axi_rvalid,  // Read data valid.
	input wire logic       s_axi_rready,  // Read data ready.
	input wire logic [1:0] s_axi_rresp,   // Read response.
	input wire logic       o_a_match_ff,  // Match pulse.
	input wire logic       o_irq_ff       // Interrupt level.
);
	// All checks run on the system clock; all but a_rst rest during reset.
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	property p_rst; disable iff (1'b0) i_sys_rst |=> !o_irq_ff && !o_a_match_ff; endproperty
	a_rst: assert property (p_rst) else $error("output high after reset");
	property p_match; o_a_match_ff |=> !o_a_match_ff; endproperty
	a_match: assert property (p_match) else $error("match pulse too long");
	property p_aw; s_axi_awready |=> !s_axi_awready; endproperty
	a_aw: assert property (p_aw) else $error("awready held");
	property p_w; s_axi_wready |=> !s_axi_wready; endproperty
	a_w: assert property (p_w) else $error("wready held");
	property p_bonce; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_bonce: assert property (p_bonce) else $error("double write response");
	property p_ronce; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_ronce: assert property (p_ronce) else $error("double read response");
	property p_rans; s_axi_arvalid && s_axi_arready |=> ##[0:2] s_axi_rvalid; endproperty
	a_rans: assert property (p_rans) else $error("read answer late");
	property p_rresp;
		s_axi_rvalid |-> s_axi_rresp == `TMCU_AXI_OKAY || s_axi_rresp == `TMCU_AXI_DECERR;
	endproperty
	a_rresp: assert property (p_rresp) else $error("bad read response");
endmodule // tmcu_props
bind tmcu_timer tmcu_props u_props (.i_sys_clk, .i_sys_rst, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rresp, .o_a_match_ff, .o_irq_ff);
`default_nettype wire

// ### verification/tb_tmcu_timer.sv
// Purpose: Self-checking bench of the timer control unit.
// Assumes: AXI4-Lite master tasks, byte address is four times the index.
// Notes: Counts are judged from elapsed cycles with a small tolerance.
`default_nettype none
module tb_tmcu_timer;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] cf = 8'hba, em = 8'hbb, al = 8'hbc, ah = 8'hbd, bl = 8'hbe;
	localparam logic [7:0] bh = 8'hbf, st = 8'hc0, mk = 8'hc1, cl = 8'hc2;
	logic        i_sys_clk = 1'b0, i_sys_rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ack = 1'b0;
	logic        ext = 1'b0, cap = 1'b0, rise = 1'b1;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, d;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  rsp;
	logic [15:0] cnt;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         mt, po, am, irq;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	int          num_errors = 0, n_checks = 0, cyc = 0, nam = 0, t0, n0;
	int          sh[7] = '{11, 9, 6, 3, 2, 1, 0};
	tmcu_timer dut (.i_sys_clk, .i_sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .i_ext_count_clock(ext),
		.i_capture_trigger_input(cap), .i_capture_rising(rise), .i_int_ack(ack),
		.o_match_toggle_out_ff(mt), .o_pulse_out_ff(po), .o_a_match_ff(am), .o_irq_ff(irq));
	// Clock, cycle count and match pulse count.
	always #5 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (am === 1'b1) nam <= nam + 1;
	end
	task results;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task tmo;
		num_errors++;
		$display("unexpected at %0t: wait ran out", $time);
		results;
	endtask
	// One AXI write of a byte register; valids drop as each channel is taken.
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		int n;
		@(posedge i_sys_clk);
		s_axi_awaddr <= {22'h0, idx, 2'h0};
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge i_sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 50) tmo;
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// One AXI read; data and response are taken at the answering edge.
	task automatic rd(input logic [7:0] idx);
		int n;
		@(posedge i_sys_clk);
		s_axi_araddr <= {22'h0, idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge i_sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 50) tmo;
		d = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task rdb;
		rd(bl);
		cnt[7:0] = d[7:0];
		rd(bh);
		cnt[15:8] = d[7:0];
	endtask
	// Pulses on the count pin or the capture pin, each level held several cycles.
	task pulses(input int n, input logic c);
		repeat (n) begin
			@(posedge i_sys_clk);
			if (c) cap <= 1'b1;
			else ext <= 1'b1;
			repeat (4) @(posedge i_sys_clk);
			cap <= 1'b0;
			ext <= 1'b0;
			repeat (3) @(posedge i_sys_clk);
		end
		repeat (6) @(posedge i_sys_clk);
	endtask
	task t_reset;
		rd(cf); chk(d, 32'h0);
		rd(al); chk(d, 32'hff);
		rd(8'h10); chk(rsp, 2'h3);
		wr(8'h10, 8'h00); chk(rsp, 2'h3);
		wr(em, 8'h7f); chk(rsp, 2'h0);
		rd(em); chk(d, 32'h30);
		wr(em, 8'h00);
	endtask
	// Internal taps: counts over a fixed window follow the division rate.
	task t_csel;
		for (int c = 0; c <= 6; c++) begin
			wr(cf, {c[2:0], 5'h0}); wr(em, 8'h80); wr(em, 8'h81);
			t0 = cyc;
			// The two slowest taps need a longer window to tick a few times.
			repeat ((c < 2) ? 4096 : 256) @(posedge i_sys_clk);
			wr(cf, {c[2:0], 5'h1});
			n0 = cyc - t0;
			rdb;
			n0 = (n0 >> sh[c]) - int'(cnt);
			chk(n0 >= -3 && n0 <= 3, 1);
			rd(cf); chk(d, {c[2:0], 5'h0});
		end
		wr(em, 8'h00);
	endtask
	// Pin clock on either edge; the clear bit zeroes the count.
	task t_ext;
		for (int e = 0; e < 2; e++) begin
			wr(cf, {6'h38, e[0], 1'b0}); wr(em, 8'h80);
			pulses(5, 1'b0);
			wr(cf, {6'h38, e[0], 1'b1}); rdb; chk(cnt, 16'h5);
			wr(em, 8'h81); rd(cl); chk(d, 32'h0);
			wr(em, 8'h00);
		end
	endtask
	task t_capture;
		wr(cf, 8'he2); wr(em, 8'h90);
		pulses(3, 1'b0); pulses(1, 1'b1);
		rdb; chk(cnt, 16'h3);
		rd(st); chk(d[1], 1'b1);
		// Falling-edge capture: B is loaded as the capture pulse ends, with the count at 5.
		rise <= 1'b0; pulses(2, 1'b0); pulses(1, 1'b1);
		rdb; chk(cnt, 16'h5);
		wr(st, 8'h03); wr(em, 8'h00);
	endtask
	task t_match;
		int n;
		wr(al, 8'h03); wr(ah, 8'h00); wr(mk, 8'h01); wr(cf, 8'hc0); wr(em, 8'h80);
		for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge i_sys_clk);
		if (irq !== 1'b1) tmo;
		chk(irq, 1'b1);
		wr(em, 8'h00); chk(nam > 0, 1);
		rd(cl); chk(d <= 3, 1);
		rd(cf); chk(d, 32'hd0);
		wr(cf, 8'hd0); rd(cf); chk(d, 32'hd0);
		@(posedge i_sys_clk) ack <= 1'b1;
		@(posedge i_sys_clk) ack <= 1'b0;
		rd(cf); chk(d, 32'hc0);
		wr(em, 8'h80); repeat (20) @(posedge i_sys_clk); wr(em, 8'h00);
		wr(cf, 8'hc0); rd(cf); chk(d, 32'hc0);
		wr(st, 8'h01); repeat (3) @(posedge i_sys_clk); chk(irq, 1'b0);
		wr(mk, 8'h00); wr(em, 8'h90); repeat (20) @(posedge i_sys_clk);
		chk(irq, 1'b0);
		rd(st); chk(d[0], 1'b1);
		wr(em, 8'h00); wr(st, 8'h03);
	endtask
	// Pulse modes: one period only, then repeating periods.
	task t_pulse;
		int n1;
		n1 = 0;
		wr(bl, 8'h02); wr(bh, 8'h00);
		n0 = nam; wr(em, 8'ha0); repeat (40) @(posedge i_sys_clk);
		chk(nam - n0, 1);
		chk(po, 1'b0);
		wr(em, 8'h00); n0 = nam; wr(em, 8'hb0);
		// Period is four ticks and duty two, so the output is high half the time.
		repeat (40) begin
			@(posedge i_sys_clk);
			if (po === 1'b1) n1++;
		end
		chk(nam - n0 > 5, 1);
		chk(n1 >= 18 && n1 <= 22, 1);
		wr(em, 8'h00); wr(cf, 8'h04); repeat (3) @(posedge i_sys_clk);
		chk(mt, 1'b1); chk(po, 1'b1);
		wr(cf, 8'h00); repeat (3) @(posedge i_sys_clk);
		chk(mt, 1'b0); chk(po, 1'b0);
	endtask
	initial begin
		repeat (20) @(posedge i_sys_clk);
		i_sys_rst <= 1'b0;
		t_reset;
		t_csel;
		t_ext;
		t_capture;
		t_match;
		t_pulse;
		results;
	end
endmodule // tb_tmcu_timer
`default_nettype wire
